/* File: rtl/vmsr_pkg.sv */
// constants, types and helpers for the margin-low, slew-rate and loop-scale registers
package vmsr_pkg;

  // command codes on the word port
  localparam logic [7:0]  CMD_MARGIN_LOW  = 8'h26;
  localparam logic [7:0]  CMD_SLEW_RATE   = 8'h27;
  localparam logic [7:0]  CMD_LOOP_SCALE  = 8'h29;

  // linear-11 field layout
  localparam int          EXP_MSB         = 15;
  localparam int          EXP_LSB         = 11;
  localparam int          MAN_MSB         = 10;

  // reset values
  localparam logic [4:0]  SLEW_EXP_RST    = 5'h1c;
  localparam logic [10:0] SLEW_MAN_RST    = 11'h010;
  localparam logic [4:0]  SCALE_EXP_RST   = 5'h19;
  localparam logic [10:0] SCALE_MAN_RST   = 11'h040;
  localparam logic [15:0] MARGIN_LOW_RST  = 16'h0100;

  // operation margin field
  localparam int          MARGIN_LSB      = 4;
  localparam logic [1:0]  MARGIN_LOW_CODE = 2'h1;

  // fixed point of decoded linear values: 2^-8
  localparam int          Q_FRAC          = 8;
  localparam int          Q_ONE           = 1 << Q_FRAC;
  localparam int          SLEW_MIN_MILLI  = 67;
  localparam int          SLEW_MAX_MILLI  = 15933;
  localparam int          SLEW_MIN_Q      = (SLEW_MIN_MILLI * Q_ONE + 999) / 1000;
  localparam int          SLEW_MAX_Q      = (SLEW_MAX_MILLI * Q_ONE) / 1000;
  localparam int          SLEW_STEP_Q     = Q_ONE / 16;
  localparam int          SCALE_Q_8TH     = Q_ONE / 8;
  localparam int          SCALE_Q_4TH     = Q_ONE / 4;
  localparam int          SCALE_Q_HALF    = Q_ONE / 2;

  // output voltage code: lsb of 2^-9 V
  localparam int          VOUT_FRAC       = 9;
  localparam int          VOUT_LSB_Q      = (1000 * Q_ONE) >> VOUT_FRAC;
  localparam int          LIM_MV_NONE     = 700;
  localparam int          LIM_MV_HALF     = 1400;
  localparam int          LIM_MV_4TH      = 2800;
  localparam int          LIM_MV_8TH      = 6000;

  // timing: rate is mV/us, clock is 100 ns
  localparam int          US_NS           = 1000;
  localparam int          CLK_NS          = 100;
  localparam int          CYC_PER_US      = US_NS / CLK_NS;
  localparam int          RAMP_STEP_Q     = VOUT_LSB_Q * CYC_PER_US;

  typedef enum logic [1:0] {DIV_8TH, DIV_4TH, DIV_HALF, DIV_NONE} vmsr_div_t;

  // decoded linear-11 value, scaled by 2^Q_FRAC
  function automatic int lin11_q(input logic [15:0] w);
    int e;
    int m;
    e = int'($signed(w[EXP_MSB:EXP_LSB])) + Q_FRAC;
    m = int'($signed(w[MAN_MSB:0]));
    if (e >= 0)
      return m <<< e;
    return m >>> (-e);
  endfunction

  function automatic vmsr_div_t div_of(input logic [15:0] w);
    int q;
    q = lin11_q(w);
    if (q <= SCALE_Q_8TH)
      return DIV_8TH;
    if (q <= SCALE_Q_4TH)
      return DIV_4TH;
    if (q <= SCALE_Q_HALF)
      return DIV_HALF;
    return DIV_NONE;
  endfunction

  function automatic int vout_limit(input vmsr_div_t d);
    case (d)
      DIV_8TH:  return (LIM_MV_8TH << VOUT_FRAC) / 1000;
      DIV_4TH:  return (LIM_MV_4TH << VOUT_FRAC) / 1000;
      DIV_HALF: return (LIM_MV_HALF << VOUT_FRAC) / 1000;
      default:  return (LIM_MV_NONE << VOUT_FRAC) / 1000;
    endcase
  endfunction

endpackage

/* File: rtl/vmsr_slew.sv */
// reference ramp that walks the output code toward its target at a programmed rate
`timescale 1ns/10ps
`default_nettype none
module vmsr_slew (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // control
  input  wire logic        bypass,
  input  wire logic [15:0] rate_q,
  input  wire logic [15:0] target,
  // reference
  output logic      [15:0] vref
);
  import vmsr_pkg::*;

  logic [15:0] acc;
  logic [16:0] acc_sum;

  assign acc_sum = {1'b0, acc} + {1'b0, rate_q};

  // one code step per cycle at most: the highest rate stays below RAMP_STEP_Q
  always_ff @(posedge clk) begin
    if (rst) begin
      vref <= 16'h0000;
      acc  <= 16'h0000;
    end else if (bypass) begin
      vref <= target;
      acc  <= 16'h0000;
    end else if (vref == target) begin
      acc  <= 16'h0000;
    end else if (acc_sum >= 17'(RAMP_STEP_Q)) begin
      acc  <= 16'(acc_sum - 17'(RAMP_STEP_Q));
      vref <= (target > vref) ? vref + 16'h0001 : vref - 16'h0001;
    end else begin
      acc  <= acc_sum[15:0];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/vmsr_regs.sv */
// margin-low, output slew rate and loop scale setpoint registers with reference control
// Summary of operation
// - margin low selected: target is margin-low setpoint plus trim offset
// - margin transitions ramp at the programmed slew rate, never step
// - margin-low setpoint is a 16-bit word written and read back by the host
// - out-of-range writes to the three registers are dropped and flag a data fault
// - slew rate applies to normal changes, not to turn-on or turn-off ramps
// - slew exponent in bits 15:11 resets to minus four, 1/16 mV/us steps
// - slew mantissa in bits 10:0 loads from nonvolatile memory
// - valid slew codes read back unchanged; hardware uses nearest 1/16 mV/us
// - slew settings accepted only from 0.067 to 15.933 mV/us
// - loop scale reaches hardware at once when disabled; held while converting
// - loop scale sets the command-to-loop-input voltage mapping
// - loop scale selects the internal feedback divider setting
// - target above the maximum limit is clamped, and while converting raises the max/min warning
// - decoded scale is quantized to 1/8, 1/4, 1/2 or 1
`timescale 1ns/10ps
`default_nettype none
module vmsr_regs (
  // clock and reset
  input  wire logic                     CLK_SYS,
  input  wire logic                     RST,
  // host word port
  input  wire logic                     CMD_WRITE,
  input  wire logic                     CMD_READ,
  input  wire logic [7:0]               CMD_CODE,
  input  wire logic [15:0]              CMD_WDATA,
  output logic      [15:0]              RDATA,
  output logic                          RDATA_VALID,
  // nonvolatile memory and supply
  input  wire logic                     NVM_LOAD,
  input  wire logic [15:0]              NVM_MARGIN_LOW,
  input  wire logic [10:0]              NVM_SLEW_MANTISSA,
  input  wire logic [15:0]              NVM_LOOP_SCALE,
  input  wire logic                     UNDERVOLTAGE_LOCKOUT,
  // converter state
  input  wire logic [7:0]               OPERATION,
  input  wire logic                     CONV_EN,
  input  wire logic                     ONOFF_RAMP,
  input  wire logic [15:0]              VOUT_COMMAND,
  input  wire logic [15:0]              VOUT_TRIM,
  input  wire logic [15:0]              VOUT_MAX,
  // status
  input  wire logic                     STATUS_CLEAR,
  output logic                          DATA_FAULT,
  output logic                          MAX_MIN_WARN,
  output logic                          HOST_ALERT,
  // reference and divider
  output logic      [15:0]              VREF_TARGET,
  output logic      [15:0]              VREF,
  output logic      [15:0]              LOOP_SCALE_HW,
  output vmsr_pkg::vmsr_div_t           DIVIDER_SEL
);
  import vmsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [15:0]        margin_low_value;
  logic [15:0]        output_slew_rate;
  logic [15:0]        loop_scale_factor;
  logic [15:0]        next_scale_hw;
  logic [15:0]        rate_hw;
  logic [15:0]        next_target;
  logic signed [17:0] trim_s;
  logic signed [17:0] wr_sum;
  logic signed [17:0] tgt_sum;
  logic               margin_active;
  logic               clamp_hi;
  logic               wr_margin;
  logic               wr_slew;
  logic               wr_scale;
  logic               margin_ok;
  logic               slew_ok;
  logic               scale_ok;
  logic               wr_bad;
  int                 wr_q;
  int                 slew_q;

  assign wr_margin     = CMD_WRITE && (CMD_CODE == CMD_MARGIN_LOW);
  assign wr_slew       = CMD_WRITE && (CMD_CODE == CMD_SLEW_RATE);
  assign wr_scale      = CMD_WRITE && (CMD_CODE == CMD_LOOP_SCALE);
  assign trim_s        = 18'(signed'(VOUT_TRIM));
  assign margin_active = OPERATION[MARGIN_LSB +: 2] == MARGIN_LOW_CODE;

  ////////////////////////////////////////////////////////////////////////
  // write validity
  always_comb begin
    wr_q      = lin11_q(CMD_WDATA);
    wr_sum    = signed'({2'b00, CMD_WDATA}) + trim_s;
    // limit follows the divider actually in use
    margin_ok = (wr_sum >= 0) && (int'(wr_sum) <= vout_limit(DIVIDER_SEL));
    slew_ok   = (wr_q >= SLEW_MIN_Q) && (wr_q <= SLEW_MAX_Q);
    scale_ok  = (wr_q > 0) && (wr_q <= Q_ONE);
    wr_bad    = (wr_margin && !margin_ok) || (wr_slew && !slew_ok) || (wr_scale && !scale_ok);
  end

  ////////////////////////////////////////////////////////////////////////
  // stored registers
  always_ff @(posedge CLK_SYS) begin
    if (RST)
      margin_low_value <= MARGIN_LOW_RST;
    else if (NVM_LOAD)
      margin_low_value <= NVM_MARGIN_LOW;
    else if (wr_margin && margin_ok)
      margin_low_value <= CMD_WDATA;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST)
      output_slew_rate <= {SLEW_EXP_RST, SLEW_MAN_RST};
    else if (NVM_LOAD)
      output_slew_rate <= {SLEW_EXP_RST, NVM_SLEW_MANTISSA};
    else if (wr_slew && slew_ok)
      output_slew_rate <= CMD_WDATA;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST)
      loop_scale_factor <= {SCALE_EXP_RST, SCALE_MAN_RST};
    else if (NVM_LOAD)
      loop_scale_factor <= NVM_LOOP_SCALE;
    else if (wr_scale && scale_ok)
      loop_scale_factor <= CMD_WDATA;
  end

  ////////////////////////////////////////////////////////////////////////
  // loop scale into hardware: held while converting, released by restore or lockout
  always_comb begin
    next_scale_hw = LOOP_SCALE_HW;
    if (NVM_LOAD)
      next_scale_hw = NVM_LOOP_SCALE;
    else if (UNDERVOLTAGE_LOCKOUT)
      next_scale_hw = loop_scale_factor;
    else if (wr_scale && scale_ok && !CONV_EN)
      next_scale_hw = CMD_WDATA;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      LOOP_SCALE_HW <= {SCALE_EXP_RST, SCALE_MAN_RST};
      DIVIDER_SEL   <= DIV_HALF;
    end else begin
      LOOP_SCALE_HW <= next_scale_hw;
      DIVIDER_SEL   <= div_of(next_scale_hw);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // target voltage; recomputed every cycle so setpoint or trim rewrites follow
  always_comb begin
    tgt_sum     = (margin_active ? signed'({2'b00, margin_low_value})
                                 : signed'({2'b00, VOUT_COMMAND})) + trim_s;
    clamp_hi    = tgt_sum > signed'({2'b00, VOUT_MAX});
    next_target = tgt_sum[15:0];
    if (clamp_hi)
      next_target = VOUT_MAX;
    else if (tgt_sum < 0)
      next_target = 16'h0000;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST)
      VREF_TARGET <= 16'h0000;
    else
      VREF_TARGET <= next_target;
  end

  // hardware rate rounded to the nearest 1/16 mV/us
  always_comb begin
    slew_q  = lin11_q(output_slew_rate);
    rate_hw = 16'(((slew_q + SLEW_STEP_Q / 2) / SLEW_STEP_Q) * SLEW_STEP_Q);
  end

  // turn-on and turn-off ramps belong to soft start, so the reference follows directly
  vmsr_slew u_slew (
    .clk    (CLK_SYS),
    .rst    (RST),
    .bypass (ONOFF_RAMP),
    .rate_q (rate_hw),
    .target (VREF_TARGET),
    .vref   (VREF)
  );

  ////////////////////////////////////////////////////////////////////////
  // sticky status; a new event in the clearing cycle wins
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      DATA_FAULT   <= 1'b0;
      MAX_MIN_WARN <= 1'b0;
      HOST_ALERT   <= 1'b0;
    end else begin
      DATA_FAULT   <= (DATA_FAULT && !STATUS_CLEAR) || wr_bad;
      MAX_MIN_WARN <= (MAX_MIN_WARN && !STATUS_CLEAR) || (clamp_hi && CONV_EN);
      HOST_ALERT   <= ((DATA_FAULT || MAX_MIN_WARN) && !STATUS_CLEAR) || wr_bad || (clamp_hi && CONV_EN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // word reads; unmapped codes answer zero
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA       <= 16'h0000;
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= CMD_READ;
      if (!CMD_READ)
        RDATA <= RDATA;
      else if (CMD_CODE == CMD_MARGIN_LOW)
        RDATA <= margin_low_value;
      else if (CMD_CODE == CMD_SLEW_RATE)
        RDATA <= output_slew_rate;
      else if (CMD_CODE == CMD_LOOP_SCALE)
        RDATA <= loop_scale_factor;
      else
        RDATA <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_margin_target;
    margin_active && !clamp_hi && tgt_sum >= 0 |=> VREF_TARGET == $past(margin_low_value + VOUT_TRIM);
  endproperty
  a_margin_target: assert property (p_margin_target) else $error("margin target wrong");

  property p_ramp_step;
    !ONOFF_RAMP && VREF != VREF_TARGET ##1 !ONOFF_RAMP |-> (VREF - $past(VREF) <= 16'h0001)
      || ($past(VREF) - VREF <= 16'h0001);
  endproperty
  a_ramp_step: assert property (p_ramp_step) else $error("reference stepped");

  property p_onoff_direct;
    ONOFF_RAMP |=> VREF == $past(VREF_TARGET);
  endproperty
  a_onoff_direct: assert property (p_onoff_direct) else $error("on-off ramp slewed");

  property p_margin_readback;
    wr_margin && margin_ok && !NVM_LOAD ##1 CMD_READ && CMD_CODE == CMD_MARGIN_LOW
      |=> RDATA_VALID && RDATA == $past(CMD_WDATA, 2);
  endproperty
  a_margin_readback: assert property (p_margin_readback) else $error("margin readback");

  property p_bad_write;
    wr_bad && !NVM_LOAD |=> DATA_FAULT && HOST_ALERT && $stable(margin_low_value)
      && $stable(output_slew_rate) && $stable(loop_scale_factor);
  endproperty
  a_bad_write: assert property (p_bad_write) else $error("invalid write not flagged");

  property p_slew_exp_reset;
    $fell(RST) |-> output_slew_rate[EXP_MSB:EXP_LSB] == SLEW_EXP_RST;
  endproperty
  a_slew_exp_reset: assert property (@(posedge CLK_SYS) p_slew_exp_reset) else $error("slew exponent reset");

  property p_slew_nvm;
    NVM_LOAD |=> output_slew_rate == {SLEW_EXP_RST, $past(NVM_SLEW_MANTISSA)};
  endproperty
  a_slew_nvm: assert property (p_slew_nvm) else $error("slew not restored");

  property p_alert_level;
    HOST_ALERT == (DATA_FAULT || MAX_MIN_WARN);
  endproperty
  a_alert_level: assert property (p_alert_level) else $error("alert out of step");

  property p_slew_store;
    wr_slew && slew_ok && !NVM_LOAD |=> output_slew_rate == $past(CMD_WDATA);
  endproperty
  a_slew_store: assert property (p_slew_store) else $error("slew not stored");

  property p_slew_range;
    wr_slew && (lin11_q(CMD_WDATA) < SLEW_MIN_Q || lin11_q(CMD_WDATA) > SLEW_MAX_Q) |=> DATA_FAULT;
  endproperty
  a_slew_range: assert property (p_slew_range) else $error("slew range");

  property p_scale_held;
    CONV_EN && !NVM_LOAD && !UNDERVOLTAGE_LOCKOUT |=> $stable(LOOP_SCALE_HW);
  endproperty
  a_scale_held: assert property (p_scale_held) else $error("scale reached hardware");

  property p_scale_live;
    wr_scale && scale_ok && !CONV_EN && !NVM_LOAD && !UNDERVOLTAGE_LOCKOUT
      |=> LOOP_SCALE_HW == $past(CMD_WDATA) && DIVIDER_SEL == div_of($past(CMD_WDATA));
  endproperty
  a_scale_live: assert property (p_scale_live) else $error("scale not applied");

  property p_clamp;
    clamp_hi && CONV_EN |=> VREF_TARGET == $past(VOUT_MAX) && MAX_MIN_WARN;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp missing");

  property p_divider;
    DIVIDER_SEL == div_of(LOOP_SCALE_HW);
  endproperty
  a_divider: assert property (p_divider) else $error("divider mismatch");

  c_margin_ramp: cover property (margin_active && VREF != VREF_TARGET ##1 VREF == VREF_TARGET);
  c_bad_write: cover property (wr_bad ##1 DATA_FAULT);
  c_scale_held: cover property (wr_scale && scale_ok && CONV_EN);
  c_clamp_warn: cover property (clamp_hi && CONV_EN ##1 MAX_MIN_WARN);
  c_nvm_restore: cover property (NVM_LOAD ##1 LOOP_SCALE_HW == NVM_LOOP_SCALE);

endmodule
`default_nettype wire

/* File: testbench/vmsr_host.sv */
// word-level host model for the setpoint register port
`timescale 1ns/10ps
`default_nettype none
module vmsr_host (
  // clock
  input  wire logic        clk,
  // word port
  output logic             cmd_write,
  output logic             cmd_read,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        rdata_valid
);
  initial begin
    cmd_write = 1'b0;
    cmd_read  = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // idle lines show the inverse, so a stale code is never taken for a live one
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmd_write = 1'b1;
    cmd_code  = code;
    cmd_wdata = data;
    @(negedge clk);
    cmd_write = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~data;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic valid);
    @(negedge clk);
    cmd_read = 1'b1;
    cmd_code = code;
    @(negedge clk);
    cmd_read = 1'b0;
    cmd_code = ~code;
    data     = rdata;
    valid    = rdata_valid;
  endtask
  // write, then read the same code on the very next edge
  task automatic wr_rd(input logic [7:0] code, input logic [15:0] data, output logic [15:0] rd_data,
                       output logic valid);
    @(negedge clk);
    cmd_write = 1'b1;
    cmd_code  = code;
    cmd_wdata = data;
    @(negedge clk);
    cmd_write = 1'b0;
    cmd_read  = 1'b1;
    cmd_wdata = ~data;
    @(negedge clk);
    cmd_read  = 1'b0;
    cmd_code  = ~code;
    rd_data   = rdata;
    valid     = rdata_valid;
  endtask
endmodule
`default_nettype wire

/* File: testbench/vmsr_regs_tb_top.sv */
// self-checking bench for the setpoint registers and reference control
`timescale 1ns/10ps
`default_nettype none
module vmsr_regs_tb_top;
  import vmsr_pkg::*;
  localparam int LIMIT = 20000;
  localparam int SCL [9] = '{32, 33, 64, 65, 128, 129, 256, 0, 257};
  logic        clk_sys, rst, cmd_write, cmd_read, nvm_load, lockout, conv_en, onoff, status_clear;
  logic        rdata_valid, data_fault, warn, alert, vv, ok;
  logic [7:0]  cmd_code, operation;
  logic [10:0] nvm_slew;
  logic [15:0] cmd_wdata, rdata, nvm_margin, nvm_scale, vout_cmd, vout_trim, vout_max;
  logic [15:0] vref_target, vref, loop_hw, rv, w, last, mlast, hw;
  vmsr_div_t   div_sel;
  int          err_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          i;

  vmsr_host u_vmsr_host (.clk(clk_sys), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rdata(rdata), .rdata_valid(rdata_valid));

  vmsr_regs u_vmsr_regs (.CLK_SYS(clk_sys), .RST(rst), .CMD_WRITE(cmd_write), .CMD_READ(cmd_read),
    .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata), .RDATA(rdata), .RDATA_VALID(rdata_valid),
    .NVM_LOAD(nvm_load), .NVM_MARGIN_LOW(nvm_margin), .NVM_SLEW_MANTISSA(nvm_slew),
    .NVM_LOOP_SCALE(nvm_scale), .UNDERVOLTAGE_LOCKOUT(lockout), .OPERATION(operation), .CONV_EN(conv_en),
    .ONOFF_RAMP(onoff), .VOUT_COMMAND(vout_cmd), .VOUT_TRIM(vout_trim), .VOUT_MAX(vout_max),
    .STATUS_CLEAR(status_clear), .DATA_FAULT(data_fault), .MAX_MIN_WARN(warn), .HOST_ALERT(alert),
    .VREF_TARGET(vref_target), .VREF(vref), .LOOP_SCALE_HW(loop_hw), .DIVIDER_SEL(div_sel));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // a hang counts against the run instead of stalling it
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic chk1(input string name, input logic exp, input logic got);
    chk(name, {15'h0, exp}, {15'h0, got});
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input string name);
    u_vmsr_host.rd(code, rv, vv);
    chk1({name, " valid"}, 1'b1, vv);
    chk(name, exp, rv);
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic clr();
    @(negedge clk_sys);
    status_clear = 1'b1;
    @(negedge clk_sys);
    status_clear = 1'b0;
  endtask
  // no more than one code per cycle, and arrival within the rate's time
  task automatic ramp_watch(input int bound);
    logic [15:0] prev;
    int          n;
    int          big;
    prev = vref;
    big  = 0;
    for (n = 0; n < bound && vref !== vref_target; n++) begin
      @(negedge clk_sys);
      if (vref > prev + 1 || prev > vref + 1) big++;
      prev = vref;
    end
    chk("ramp jump", 16'h0, big[15:0]);
    chk("ramp end", vref_target, vref);
  endtask

  // decoded linear value in 1/256 units
  function automatic int lin_q(input logic [15:0] x);
    int e;
    int m;
    e = int'($signed(x[15:11])) + 8;
    m = int'($signed(x[10:0]));
    return (e >= 0) ? (m <<< e) : (m >>> (-e));
  endfunction
  function automatic logic slew_ok(input logic [15:0] x);
    return lin_q(x) >= 18 && lin_q(x) <= 4078;
  endfunction
  function automatic vmsr_div_t div_exp(input int q);
    if (q <= 32) return DIV_8TH;
    if (q <= 64) return DIV_4TH;
    if (q <= 128) return DIV_HALF;
    return DIV_NONE;
  endfunction

  initial begin
    {rst, nvm_load, lockout, conv_en, onoff, status_clear} = 6'h20;
    operation  = 8'h00;
    vout_cmd   = 16'h0000;
    vout_trim  = 16'h0000;
    vout_max   = 16'h0400;
    nvm_margin = 16'h0055;
    nvm_slew   = 11'h020;
    nvm_scale  = 16'hc020;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    w = 16'($urandom(32'hd76c));
    rd_chk(CMD_MARGIN_LOW, MARGIN_LOW_RST, "margin rst");
    rd_chk(CMD_SLEW_RATE, {5'h1c, SLEW_MAN_RST}, "slew rst");
    rd_chk(CMD_LOOP_SCALE, 16'hc840, "scale rst");
    rd_chk(8'h28, 16'h0000, "unmapped");
    chk("hw scale rst", 16'hc840, loop_hw);
    chk("div rst", {14'h0, DIV_HALF}, {14'h0, div_sel});
    $display("test reset done");
    last = {5'h1c, SLEW_MAN_RST};
    for (i = 0; i < 16; i++) begin
      case (i)
        0: w = 16'he002;
        1: w = 16'he001;
        2: w = 16'he0fe;
        3: w = 16'he0ff;
        4: w = 16'hf7ff;
        default: w = {5'h1b + 5'($urandom_range(2, 0)), 11'($urandom_range(520, 0))};
      endcase
      u_vmsr_host.wr(CMD_SLEW_RATE, w);
      if (slew_ok(w)) last = w;
      chk1("slew fault", !slew_ok(w), data_fault);
      chk1("slew alert", !slew_ok(w), alert);
      rd_chk(CMD_SLEW_RATE, last, "slew read");
      clr();
      chk1("fault clear", 1'b0, data_fault);
    end
    u_vmsr_host.wr(CMD_SLEW_RATE, 16'he010);
    $display("test slew done");
    operation = 8'h10;
    for (i = 0; i < 6; i++) begin
      vout_trim = 16'($urandom_range(100, 0));
      w = (i == 4) ? 16'd717 - vout_trim : (i == 5) ? 16'd716 - vout_trim : 16'($urandom_range(600, 20));
      u_vmsr_host.wr_rd(CMD_MARGIN_LOW, w, rv, vv);
      if (i != 4) mlast = w;
      chk1("margin wr valid", 1'b1, vv);
      chk("margin wr read", mlast, rv);
      chk1("margin fault", i == 4, data_fault);
      step(1);
      chk("margin target", mlast + vout_trim, vref_target);
      vout_trim = vout_trim + 16'd7;
      step(2);
      chk("trim follow", mlast + vout_trim, vref_target);
      rd_chk(CMD_MARGIN_LOW, mlast, "margin read");
      clr();
    end
    operation = 8'h00;
    vout_cmd  = 16'h0123;
    step(2);
    chk("command target", 16'h0123 + vout_trim, vref_target);
    $display("test margin done");
    conv_en   = 1'b1;
    operation = 8'h10;
    vout_max  = 16'h0040;
    step(2);
    chk("clamp", 16'h0040, vref_target);
    clr();
    chk1("warn held", 1'b1, warn);
    chk1("warn alert", 1'b1, alert);
    vout_max = 16'h0400;
    step(1);
    clr();
    chk1("warn clear", 1'b0, warn);
    chk1("alert clear", 1'b0, alert);
    $display("test clamp done");
    onoff = 1'b1;
    step(2);
    chk("onoff snap", vref_target, vref);
    onoff = 1'b0;
    u_vmsr_host.wr(CMD_MARGIN_LOW, mlast - 16'd30);
    step(1);
    chk1("no jump", 1'b1, vref !== vref_target);
    ramp_watch(30 * 5000 / 256 + 10);
    u_vmsr_host.wr(CMD_SLEW_RATE, 16'he0fe);
    u_vmsr_host.wr(CMD_MARGIN_LOW, mlast - 16'd330);
    step(1);
    ramp_watch(300 * 5000 / 4064 + 10);
    $display("test ramp done");
    conv_en = 1'b0;
    hw = 16'hc840;
    for (i = 0; i < 12; i++) begin
      w = {5'h18, 11'((i < 9) ? SCL[i] : $urandom_range(300, 1))};
      u_vmsr_host.wr(CMD_LOOP_SCALE, w);
      ok = lin_q(w) > 0 && lin_q(w) <= 256;
      if (ok) hw = w;
      step(1);
      chk1("scale fault", !ok, data_fault);
      chk("hw scale", hw, loop_hw);
      chk("divider", {14'h0, div_exp(lin_q(hw))}, {14'h0, div_sel});
      clr();
    end
    conv_en = 1'b1;
    w = (hw == 16'hc080) ? 16'hc040 : 16'hc080;
    u_vmsr_host.wr(CMD_LOOP_SCALE, w);
    step(1);
    chk1("held no fault", 1'b0, data_fault);
    chk("hw held", hw, loop_hw);
    rd_chk(CMD_LOOP_SCALE, w, "scale stored");
    nvm_load = 1'b1;
    step(1);
    nvm_load = 1'b0;
    step(1);
    chk("restore hw", nvm_scale, loop_hw);
    chk("restore div", {14'h0, DIV_8TH}, {14'h0, div_sel});
    rd_chk(CMD_MARGIN_LOW, nvm_margin, "nvm margin");
    rd_chk(CMD_SLEW_RATE, {5'h1c, nvm_slew}, "nvm slew");
    u_vmsr_host.wr(CMD_LOOP_SCALE, 16'hc040);
    step(1);
    chk("hw held 2", nvm_scale, loop_hw);
    lockout = 1'b1;
    step(1);
    lockout = 1'b0;
    step(1);
    chk("lockout hw", 16'hc040, loop_hw);
    chk("lockout div", {14'h0, DIV_4TH}, {14'h0, div_sel});
    $display("test scale done");
    test_done();
  end
endmodule
`default_nettype wire
